// ---- design/rijmp_pkg.sv ----
// Package for the relative and indirect jump unit: opcodes, timing, carriers
package rijmp_pkg;

	// ---------------------------------------------------------------
	// Opcodes
	// ---------------------------------------------------------------
	localparam logic [7:0] RIJMP_OP_REL_ALWAYS = 8'h18;
	localparam logic [7:0] RIJMP_OP_REL_AOUT_SET = 8'h38;
	localparam logic [7:0] RIJMP_OP_REL_AOUT_CLR = 8'h30;
	localparam logic [7:0] RIJMP_OP_REL_NULL_SET = 8'h28;
	localparam logic [7:0] RIJMP_OP_REL_NOT_NULL = 8'h20;
	localparam logic [7:0] RIJMP_OP_PTR_JUMP = 8'hE9;
	localparam logic [7:0] RIJMP_OP_PREFIX_FIRST = 8'hDD;
	localparam logic [7:0] RIJMP_OP_PREFIX_SECOND = 8'hFD;

	// ---------------------------------------------------------------
	// Flag positions in the flag register
	// ---------------------------------------------------------------
	localparam int RIJMP_FLAG_AOUT_POS = 0;
	localparam int RIJMP_FLAG_NULL_POS = 6;

	// ---------------------------------------------------------------
	// Clock-state counts per machine cycle, pointer reset value and instruction length
	// ---------------------------------------------------------------
	localparam logic [2:0] RIJMP_MC_FETCH_STATES = 3'h4;
	localparam logic [2:0] RIJMP_MC_READ_STATES = 3'h3;
	localparam logic [2:0] RIJMP_MC_ADD_STATES = 3'h5;
	localparam logic [2:0] RIJMP_MC_INDEX_STATES = 3'h4;
	localparam logic [15:0] RIJMP_PTR_RESET = 16'h0000;
	localparam logic [15:0] RIJMP_INSTR_LEN = 16'h0002;

	typedef enum logic [2:0] {
		RIJMP_ST_IDLE = 3'h0,
		RIJMP_ST_FETCH = 3'h1,
		RIJMP_ST_READ = 3'h3,
		RIJMP_ST_ADD = 3'h2,
		RIJMP_ST_PREFIXED = 3'h6
	} rijmp_state_type;

	// Instruction bytes handed in by the fetch logic
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} rijmp_byte_type;

	// Register file values the unit can copy from
	typedef struct packed {
		logic [15:0] main_pointer_pair;
		logic [15:0] first_index_reg;
		logic [15:0] second_index_reg;
	} rijmp_regs_type;

endpackage

// ---- design/rijmp_state_timer.sv ----
// Clock-state timer: counts the states of one machine cycle
`timescale 1ns/1ns
`default_nettype none
module rijmp_state_timer
	import rijmp_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic [2:0] length,
	output logic last,
	output logic busy
);
	logic [2:0] count_q;
	logic [2:0] count_d;

	assign last = busy && (count_q == 3'h1);
	assign count_d = start ? length : (busy ? 3'(count_q - 3'h1) : 3'h0);
	assign busy = (count_q != 3'h0);

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			count_q <= 3'h0;
		end else begin
			count_q <= count_d;
		end
	end

	AST_TIMER_LENGTH: assert property (@(posedge core_clk) disable iff (sys_rst)
		start && length == 3'h5 |=> !last [*4] ##1 last)
		else $error("machine cycle length wrong");
endmodule
`default_nettype wire

// ---- design/rijmp_unit.sv ----
// Relative and register-indirect jump execution unit
`timescale 1ns/1ns
`default_nettype none
module rijmp_unit
	import rijmp_pkg::*;
#(
	parameter int ADDR_W = 16
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire rijmp_byte_type fetch_byte,
	input wire rijmp_regs_type regs,
	input wire logic [7:0] flags_in,
	output logic [7:0] flags_out,
	output logic byte_req,
	output logic [ADDR_W-1:0] instr_pointer,
	output logic busy,
	output logic done
);
	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	function automatic logic is_rel(input logic [7:0] op);
		is_rel = (op == RIJMP_OP_REL_ALWAYS) || (op == RIJMP_OP_REL_AOUT_SET) ||
			(op == RIJMP_OP_REL_AOUT_CLR) || (op == RIJMP_OP_REL_NULL_SET) ||
			(op == RIJMP_OP_REL_NOT_NULL);
	endfunction

	function automatic logic cond_met(input logic [7:0] op, input logic [7:0] f);
		logic aout;
		logic nul;
		aout = f[RIJMP_FLAG_AOUT_POS];
		nul = f[RIJMP_FLAG_NULL_POS];
		unique case (op)
			RIJMP_OP_REL_ALWAYS: cond_met = 1'b1;
			RIJMP_OP_REL_AOUT_SET: cond_met = aout;
			RIJMP_OP_REL_AOUT_CLR: cond_met = !aout;
			RIJMP_OP_REL_NULL_SET: cond_met = nul;
			RIJMP_OP_REL_NOT_NULL: cond_met = !nul;
			default: cond_met = 1'b0;
		endcase
	endfunction

	rijmp_state_type state_q;
	rijmp_state_type state_d;
	logic [7:0] opcode_q;
	logic [7:0] prefix_q;
	logic [ADDR_W-1:0] ip_q;
	logic [ADDR_W-1:0] ip_d;
	logic [7:0] disp_q;
	logic t_start;
	logic [2:0] t_len;
	logic t_last;
	logic t_busy;

	wire take_byte = fetch_byte.valid && byte_req;
	wire op_rel = is_rel(fetch_byte.data);
	wire op_ptr = (fetch_byte.data == RIJMP_OP_PTR_JUMP);
	wire op_pre = (fetch_byte.data == RIJMP_OP_PREFIX_FIRST) ||
		(fetch_byte.data == RIJMP_OP_PREFIX_SECOND);
	wire taken = cond_met(opcode_q, flags_in);
	// The second opcode may land on the last prefix state, so that the pair takes 4 plus 4
	wire pre_slot = (state_q == RIJMP_ST_PREFIXED) && (opcode_q != RIJMP_OP_PTR_JUMP) &&
		(t_last || !t_busy);
	wire [ADDR_W-1:0] disp_ext = ADDR_W'($signed(disp_q));
	wire [ADDR_W-1:0] index_val = (prefix_q == RIJMP_OP_PREFIX_SECOND) ?
		ADDR_W'(regs.second_index_reg) : ADDR_W'(regs.first_index_reg);

	// Flags pass through untouched; this unit owns no flag writes
	assign flags_out = flags_in;
	assign instr_pointer = ip_q;
	assign busy = (state_q != RIJMP_ST_IDLE);
	assign byte_req = (state_q == RIJMP_ST_IDLE) ||
		((state_q == RIJMP_ST_FETCH) && t_last) ||
		pre_slot;

	// ---------------------------------------------------------------
	// Machine cycle timer
	// ---------------------------------------------------------------
	rijmp_state_timer u_timer (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.start(t_start),
		.length(t_len),
		.last(t_last),
		.busy(t_busy)
	);

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		ip_d = ip_q;
		t_start = 1'b0;
		t_len = RIJMP_MC_FETCH_STATES;
		done = 1'b0;
		unique case (state_q)
			RIJMP_ST_IDLE: begin
				if (take_byte && (op_rel || op_ptr || op_pre)) begin
					// Opcode fetch cycle, 4 states
					t_start = 1'b1;
					t_len = RIJMP_MC_FETCH_STATES;
					state_d = op_pre ? RIJMP_ST_PREFIXED : RIJMP_ST_FETCH;
					ip_d = ADDR_W'(ip_q + 1'b1);
				end
			end
			RIJMP_ST_FETCH: begin
				if (t_last && opcode_q == RIJMP_OP_PTR_JUMP) begin
					ip_d = ADDR_W'(regs.main_pointer_pair);
					done = 1'b1;
					state_d = RIJMP_ST_IDLE;
				end else if (t_last && take_byte) begin
					// Displacement read, 3 states; pointer then past both bytes
					t_start = 1'b1;
					t_len = RIJMP_MC_READ_STATES;
					ip_d = ADDR_W'(ip_q + 1'b1);
					state_d = RIJMP_ST_READ;
				end else if (t_last) begin
					state_d = RIJMP_ST_READ;
				end
			end
			RIJMP_ST_READ: begin
				if (t_last && taken) begin
					t_start = 1'b1;
					t_len = RIJMP_MC_ADD_STATES;
					state_d = RIJMP_ST_ADD;
				end else if (t_last) begin
					done = 1'b1;
					state_d = RIJMP_ST_IDLE;
				end
			end
			RIJMP_ST_ADD: begin
				if (t_last) begin
					ip_d = ADDR_W'(ip_q + disp_ext);
					done = 1'b1;
					state_d = RIJMP_ST_IDLE;
				end
			end
			RIJMP_ST_PREFIXED: begin
				// Second opcode fetch after the prefix, 4 more states
				if (take_byte && op_ptr) begin
					t_start = 1'b1;
					t_len = RIJMP_MC_INDEX_STATES;
					ip_d = ADDR_W'(ip_q + 1'b1);
				end else if (take_byte) begin
					// Not E9: drop the prefix, the other groups handle it
					state_d = RIJMP_ST_IDLE;
				end else if (t_last && opcode_q == RIJMP_OP_PTR_JUMP) begin
					ip_d = index_val;
					done = 1'b1;
					state_d = RIJMP_ST_IDLE;
				end
			end
			default: begin
				state_d = RIJMP_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_q <= RIJMP_ST_IDLE;
			ip_q <= RIJMP_PTR_RESET;
			opcode_q <= 8'h00;
			prefix_q <= 8'h00;
			disp_q <= 8'h00;
		end else begin
			state_q <= state_d;
			ip_q <= ip_d;
			if (state_q == RIJMP_ST_IDLE && take_byte) begin
				opcode_q <= fetch_byte.data;
				prefix_q <= op_pre ? fetch_byte.data : 8'h00;
			end else if (state_q == RIJMP_ST_PREFIXED && take_byte) begin
				opcode_q <= fetch_byte.data;
			end
			if (state_q == RIJMP_ST_FETCH && take_byte) begin
				disp_q <= fetch_byte.data;
			end
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	AST_TAKEN_ADD: assert property (@(posedge core_clk) disable iff (sys_rst)
		state_q == RIJMP_ST_ADD && t_last |=> ip_q == $past(ip_q) + $past(disp_ext))
		else $error("taken branch target wrong");
	AST_NOT_TAKEN_SEQ: assert property (@(posedge core_clk) disable iff (sys_rst)
		state_q == RIJMP_ST_READ && t_last && !taken |=> state_q == RIJMP_ST_IDLE
		&& ip_q == $past(ip_q))
		else $error("untaken branch moved pointer");
	AST_ALWAYS_TAKEN: assert property (@(posedge core_clk) disable iff (sys_rst)
		state_q == RIJMP_ST_READ && t_last && opcode_q == RIJMP_OP_REL_ALWAYS
		|=> state_q == RIJMP_ST_ADD)
		else $error("unconditional branch not taken");
	AST_AOUT_SET: assert property (@(posedge core_clk) disable iff (sys_rst)
		state_q == RIJMP_ST_READ && t_last && opcode_q == RIJMP_OP_REL_AOUT_SET
		|=> (state_q == RIJMP_ST_ADD) == $past(flags_in[RIJMP_FLAG_AOUT_POS]))
		else $error("arith-out set branch wrong");
	AST_AOUT_CLR: assert property (@(posedge core_clk) disable iff (sys_rst)
		state_q == RIJMP_ST_READ && t_last && opcode_q == RIJMP_OP_REL_AOUT_CLR
		|=> (state_q == RIJMP_ST_ADD) != $past(flags_in[RIJMP_FLAG_AOUT_POS]))
		else $error("arith-out clear branch wrong");
	AST_NULL_SET: assert property (@(posedge core_clk) disable iff (sys_rst)
		state_q == RIJMP_ST_READ && t_last && opcode_q == RIJMP_OP_REL_NULL_SET
		|=> (state_q == RIJMP_ST_ADD) == $past(flags_in[RIJMP_FLAG_NULL_POS]))
		else $error("null set branch wrong");
	AST_NOT_NULL: assert property (@(posedge core_clk) disable iff (sys_rst)
		state_q == RIJMP_ST_READ && t_last && opcode_q == RIJMP_OP_REL_NOT_NULL
		|=> (state_q == RIJMP_ST_ADD) != $past(flags_in[RIJMP_FLAG_NULL_POS]))
		else $error("not-null branch wrong");
	AST_PTR_JUMP: assert property (@(posedge core_clk) disable iff (sys_rst)
		state_q == RIJMP_ST_IDLE && take_byte && op_ptr
		|=> !done [*3] ##1 done ##1 ip_q == $past(regs.main_pointer_pair))
		else $error("pointer-pair jump wrong");
	AST_ADD_CYCLE: assert property (@(posedge core_clk) disable iff (sys_rst)
		state_q == RIJMP_ST_READ && t_last && taken
		|=> state_q == RIJMP_ST_ADD [*5] ##1 state_q == RIJMP_ST_IDLE)
		else $error("taken branch add cycle not 5 states");
	AST_INDEX_JUMP: assert property (@(posedge core_clk) disable iff (sys_rst)
		state_q == RIJMP_ST_PREFIXED && t_last && opcode_q == RIJMP_OP_PTR_JUMP
		|=> state_q == RIJMP_ST_IDLE && ip_q == $past(index_val))
		else $error("index register jump wrong");
endmodule
`default_nettype wire

// ---- tb/rijmp_fetch_model.sv ----
// Fetch-side model: hands instruction bytes to the jump unit
`timescale 1ns/1ns
`default_nettype none
module rijmp_fetch_model
	import rijmp_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic byte_req,
	input wire logic [1:0] stall,
	output var rijmp_byte_type fetch_byte
);
	logic [7:0] q[$];
	int wait_cnt = 0;
	initial fetch_byte = '0;
	task automatic push(input logic [7:0] b);
		q.push_back(b);
	endtask
	// ---------------------------------------------------------------
	// Byte hand-over
	// ---------------------------------------------------------------
	always @(posedge core_clk) begin
		if (sys_rst) begin
			q.delete();
		end else if (fetch_byte.valid && byte_req) begin
			void'(q.pop_front());
			wait_cnt = stall;
		end
	end
	// A stall of at most 3 still lands the displacement by its fetch slot
	// Idle data toggles so a stale byte never looks like a good one
	always @(negedge core_clk) begin
		if (wait_cnt > 0) wait_cnt--;
		fetch_byte.valid <= (q.size() > 0) && (wait_cnt == 0);
		fetch_byte.data <= (q.size() > 0 && wait_cnt == 0) ? q[0] : ~fetch_byte.data;
	end
endmodule
`default_nettype wire

// ---- tb/tb_relative_and_indirect_jump_unit.sv ----
// Testbench for the relative and indirect jump unit
`timescale 1ns/1ns
`default_nettype none
module tb_relative_and_indirect_jump_unit
	import rijmp_pkg::*;
;
	logic core_clk, sys_rst, byte_req, busy, done, take;
	rijmp_byte_type fetch_byte;
	rijmp_regs_type regs;
	logic [7:0] flags_in, flags_out, op, d;
	logic [15:0] instr_pointer, nxt;
	logic [1:0] stall;
	logic [31:0] r1, r2;
	logic [7:0] ops [5] = '{8'h18, 8'h38, 8'h30, 8'h28, 8'h20};
	int error_cnt = 0, checked = 0, seed = 47, cyc = 0, t0 = 0, dur = 0, n_done = 0;
	logic [15:0] ip_m = 16'h0000;

	rijmp_unit #(.ADDR_W(16)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.fetch_byte(fetch_byte), .regs(regs), .flags_in(flags_in), .flags_out(flags_out),
		.byte_req(byte_req), .instr_pointer(instr_pointer), .busy(busy), .done(done));
	rijmp_fetch_model i_fetch (.core_clk(core_clk), .sys_rst(sys_rst), .byte_req(byte_req),
		.stall(stall), .fetch_byte(fetch_byte));

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// ---------------------------------------------------------------
	// Timing monitor: cycles from opcode take to done
	// ---------------------------------------------------------------
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (fetch_byte.valid && byte_req && !busy) t0 <= cyc;
		if (done === 1'b1) begin
			dur <= cyc - t0;
			n_done <= n_done + 1;
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic exec(input logic [7:0] b0, input logic [7:0] b1, input int nb,
		input logic [15:0] exp_ip, input int n);
		int k;
		int w;
		k = n_done;
		w = 0;
		i_fetch.push(b0);
		if (nb > 1) i_fetch.push(b1);
		while (n_done == k && w < 60) begin
			@(negedge core_clk);
			w++;
		end
		check("completion", w < 60, 1);
		check("duration", dur, n);
		check("pointer", instr_pointer, exp_ip);
		check("flags", flags_out, flags_in);
		ip_m = exp_ip;
	endtask

	initial begin
		#100000;
		error_cnt++;
		give_verdict();
	end
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		sys_rst = 1'b1;
		regs = '0;
		flags_in = 8'h00;
		stall = 2'h0;
		repeat (6) @(negedge core_clk);
		check("reset pointer", instr_pointer, 16'h0000);
		check("reset busy", {busy, done, byte_req}, 3'h1);
		sys_rst = 1'b0;
		$display("test reset finished");
		// Both flag states for every condition code, reach limits first
		for (int i = 0; i < 20; i++) begin
			op = ops[i % 5];
			flags_in = $random(seed);
			flags_in[0] = ((i / 5) % 2 == 1);
			flags_in[6] = ((i / 5) % 2 == 1);
			stall = $random(seed);
			d = $random(seed);
			if (i == 0 || i == 5) d = (i == 5) ? 8'h80 : 8'h7F;
			take = (op == 8'h18) | (op == 8'h38 & flags_in[0]) | (op == 8'h30 & !flags_in[0])
				| (op == 8'h28 & flags_in[6]) | (op == 8'h20 & !flags_in[6]);
			nxt = ip_m + 16'h0002;
			exec(op, d, 2, take ? nxt + {{8{d[7]}}, d} : nxt, take ? 12 : 7);
		end
		$display("test relative branches finished");
		for (int j = 0; j < 4; j++) begin
			r1 = $random(seed);
			r2 = $random(seed);
			regs = {r1[15:0], r1[31:16], r2[15:0]};
			stall = $random(seed);
			exec(8'hE9, 8'h00, 1, regs.main_pointer_pair, 4);
			exec(8'hDD, 8'hE9, 2, regs.first_index_reg, 8);
			exec(8'hFD, 8'hE9, 2, regs.second_index_reg, 8);
		end
		$display("test indirect jumps finished");
		i_fetch.push(8'h00);
		repeat (8) @(negedge core_clk);
		check("ignored pointer", instr_pointer, ip_m);
		check("ignored busy", busy, 1'b0);
		$display("test ignored byte finished");
		i_fetch.push(8'h18);
		i_fetch.push(8'h05);
		repeat (3) @(negedge core_clk);
		sys_rst = 1'b1;
		repeat (2) @(negedge core_clk);
		check("rerun pointer", instr_pointer, 16'h0000);
		check("rerun busy", {busy, done, byte_req}, 3'h1);
		sys_rst = 1'b0;
		ip_m = 16'h0000;
		exec(8'hE9, 8'h00, 1, regs.main_pointer_pair, 4);
		$display("test mid-run reset finished");
		give_verdict();
	end
endmodule
`default_nettype wire
